// ===== dcc_map.svh
`ifndef DCC_MAP_SVH
`define DCC_MAP_SVH

// register byte offsets
`define DCC_CTRL_OFS 8'h00
`define DCC_SWTRIG_OFS 8'h04
`define DCC_HOLD_OFS 8'h08
`define DCC_DOUT_OFS 8'h0c

// control register field positions
`define DCC_EN_BIT 16
`define DCC_BUFOFF_BIT 17
`define DCC_TRGEN_BIT 18
`define DCC_TSEL_LSB 19
`define DCC_WAVE_LSB 22
`define DCC_MAMP_LSB 24

// software trigger bit in its register
`define DCC_SW_BIT 1

// reset values
`define DCC_LFSR_RST 12'haaa
`define DCC_CTRL_RST 32'h0000_0000

// axi responses
`define DCC_RESP_OKAY 2'b00
`define DCC_RESP_SLVERR 2'b10

`endif

// ===== dcc_pkg.sv
package dcc_pkg;

    typedef enum logic [2:0] {
        DCC_TSEL_TIM6 = 3'h0,
        DCC_TSEL_TIM3 = 3'h1,
        DCC_TSEL_TIM7 = 3'h2,
        DCC_TSEL_TIM15 = 3'h3,
        DCC_TSEL_TIM2 = 3'h4,
        DCC_TSEL_RSVD = 3'h5,
        DCC_TSEL_EINT9 = 3'h6,
        DCC_TSEL_SW = 3'h7
    } dcc_tsel_e;

    typedef enum logic [1:0] {
        DCC_WAVE_NONE = 2'h0,
        DCC_WAVE_NOISE = 2'h1,
        DCC_WAVE_TRI = 2'h2,
        DCC_WAVE_TRI2 = 2'h3
    } dcc_wave_e;

    typedef enum logic [1:0] {
        DCC_WR_COLLECT = 2'b01,
        DCC_WR_RESP = 2'b10
    } dcc_wr_e;

    typedef enum logic [1:0] {
        DCC_RD_IDLE = 2'b01,
        DCC_RD_RESP = 2'b10
    } dcc_rd_e;

endpackage

// ===== dcc_ch2_ctrl.sv
// Functional notes
// [R1] Bit 16 set enables channel two; cleared keeps it disabled.
// [R2] Bit 17 clear keeps output buffer on; set bypasses it.
// [R3] Trigger events are accepted only while trigger enable is one.
// [R4] Trigger source selection takes effect only while trigger enable is set.
// [R5] Codes 000, 001, 011 select timer six, timer three, timer fifteen.
// [R6] Code 100 selects timer two; code 101 is reserved, no source.
// [R7] Code 110 takes the trigger from external interrupt line 9.
// [R8] Code 111 uses a software-issued trigger.
// [R9] Wave field 00 generates no waveform; output follows written data.
// [R10] Wave field upper bit one produces a triangle waveform.
// [R11] Selector masks noise bits or sets triangle peak amplitude.
// [R12] Wave field 01 generates pseudo-random noise.
// [R13] Code 010 selects basic timer seven.
// [R14] Triggered mode loads output on trigger; otherwise on next clock.
`timescale 1ns/100ps
`include "dcc_map.svh"

module dcc_ch2_ctrl #(
    parameter int DAC_W = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic basic_timer_six_trig,
    input wire logic basic_timer_seven_trig,
    input wire logic general_timer_three_trig,
    input wire logic general_timer_fifteen_trig,
    input wire logic general_timer_two_trig,
    input wire logic eint_line9_trig,
    output logic ch2_enable,
    output logic ch2_output_buffer_off,
    output logic [DAC_W-1:0] ch2_data_out,
    output logic ch2_conv_strobe
);
    import dcc_pkg::*;

    typedef struct packed {
        logic en;
        logic bufoff;
        logic trgen;
        dcc_tsel_e tsel;
        dcc_wave_e wave;
        logic [3:0] mamp;
        logic [DAC_W-1:0] hold;
        logic [DAC_W-1:0] dout;
        logic [DAC_W-1:0] lfsr;
        logic [DAC_W-1:0] tri_cnt;
        logic tri_down;
        logic sw_pend;
        logic strobe;
        dcc_wr_e wst;
        logic aw_got;
        logic w_got;
        logic [7:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        dcc_rd_e rst;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } dcc_state_s;

    dcc_state_s s_ff;
    dcc_state_s nxt_s;

    logic [DAC_W-1:0] mask;
    logic sel_evt;
    logic trig_evt;
    logic xfer;
    logic wr_do;
    logic [DAC_W-1:0] lfsr_nx;
    logic [DAC_W-1:0] tri_nx;
    logic tri_dn_nx;
    logic [31:0] ctrl_word;
    logic [31:0] wr_merged;

    function automatic logic [DAC_W-1:0] amp_mask(input logic [3:0] m);
        logic [DAC_W-1:0] r;
        r = '0;
        for (int i = 0; i < DAC_W; i++) begin
            r[i] = (i <= int'(m));
        end
        return r;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    assign mask = amp_mask(s_ff.mamp); // see [R11]

    always_comb begin
        ctrl_word = `DCC_CTRL_RST;
        ctrl_word[`DCC_EN_BIT] = s_ff.en;
        ctrl_word[`DCC_BUFOFF_BIT] = s_ff.bufoff;
        ctrl_word[`DCC_TRGEN_BIT] = s_ff.trgen;
        ctrl_word[`DCC_TSEL_LSB +: 3] = s_ff.tsel;
        ctrl_word[`DCC_WAVE_LSB +: 2] = s_ff.wave;
        ctrl_word[`DCC_MAMP_LSB +: 4] = s_ff.mamp;
    end

    assign wr_do = (s_ff.wst == DCC_WR_COLLECT) && s_ff.aw_got && s_ff.w_got;

    always_comb begin
        case (s_ff.waddr)
            `DCC_CTRL_OFS: wr_merged = merge(ctrl_word, s_ff.wdata,
                                             s_ff.wstrb);
            `DCC_HOLD_OFS: wr_merged = merge(32'(s_ff.hold), s_ff.wdata,
                                             s_ff.wstrb);
            default: wr_merged = merge(32'h0000_0000, s_ff.wdata,
                                       s_ff.wstrb);
        endcase
    end

    // source selection, ignored unless triggering is enabled
    always_comb begin
        case (s_ff.tsel)
            DCC_TSEL_TIM6: sel_evt = basic_timer_six_trig; // see [R5]
            DCC_TSEL_TIM3: sel_evt = general_timer_three_trig; // see [R5]
            DCC_TSEL_TIM7: sel_evt = basic_timer_seven_trig; // see [R13]
            DCC_TSEL_TIM15: sel_evt = general_timer_fifteen_trig; // see [R5]
            DCC_TSEL_TIM2: sel_evt = general_timer_two_trig; // see [R6]
            DCC_TSEL_EINT9: sel_evt = eint_line9_trig; // see [R7]
            DCC_TSEL_SW: sel_evt = s_ff.sw_pend; // see [R8]
            default: sel_evt = 1'b0; // see [R6]
        endcase
    end

    assign trig_evt = s_ff.trgen & sel_evt; // see [R3] see [R4]
    assign xfer = s_ff.en & (s_ff.trgen ? trig_evt : 1'b1); // see [R14]

    assign lfsr_nx = {s_ff.lfsr[DAC_W-2:0],
                      s_ff.lfsr[DAC_W-1] ^ s_ff.lfsr[5] ^
                      s_ff.lfsr[3] ^ s_ff.lfsr[0]}; // see [R12]

    // triangle turns at the selected peak and at zero
    always_comb begin
        if (!s_ff.tri_down && (s_ff.tri_cnt < mask)) begin
            tri_nx = s_ff.tri_cnt + DAC_W'(1);
            tri_dn_nx = 1'b0;
        end else if (s_ff.tri_cnt != '0) begin
            tri_nx = s_ff.tri_cnt - DAC_W'(1);
            tri_dn_nx = 1'b1;
        end else begin
            tri_nx = s_ff.tri_cnt + DAC_W'(1);
            tri_dn_nx = 1'b0;
        end
    end // see [R10] see [R11]

    always_comb begin
        nxt_s = s_ff;
        nxt_s.strobe = 1'b0;
        // write channel
        case (s_ff.wst)
            DCC_WR_COLLECT: begin
                if (s_axi_awvalid && s_ff.awready) begin
                    nxt_s.aw_got = 1'b1;
                    nxt_s.waddr = s_axi_awaddr;
                end
                if (s_axi_wvalid && s_ff.wready) begin
                    nxt_s.w_got = 1'b1;
                    nxt_s.wdata = s_axi_wdata;
                    nxt_s.wstrb = s_axi_wstrb;
                end
                nxt_s.awready = !nxt_s.aw_got;
                nxt_s.wready = !nxt_s.w_got;
                if (wr_do) begin
                    nxt_s.awready = 1'b0;
                    nxt_s.wready = 1'b0;
                    nxt_s.bvalid = 1'b1;
                    nxt_s.bresp = `DCC_RESP_OKAY;
                    nxt_s.wst = DCC_WR_RESP;
                    case (s_ff.waddr)
                        `DCC_CTRL_OFS: begin
                            nxt_s.en = wr_merged[`DCC_EN_BIT]; // see [R1]
                            nxt_s.bufoff = wr_merged[`DCC_BUFOFF_BIT]; // see [R2]
                            nxt_s.trgen = wr_merged[`DCC_TRGEN_BIT];
                            nxt_s.tsel = dcc_tsel_e'(
                                wr_merged[`DCC_TSEL_LSB +: 3]);
                            nxt_s.wave = dcc_wave_e'(
                                wr_merged[`DCC_WAVE_LSB +: 2]);
                            nxt_s.mamp = wr_merged[`DCC_MAMP_LSB +: 4];
                        end
                        `DCC_SWTRIG_OFS: begin
                        end
                        `DCC_HOLD_OFS: begin
                            nxt_s.hold = wr_merged[DAC_W-1:0];
                        end
                        default: begin
                            nxt_s.bresp = `DCC_RESP_SLVERR;
                        end
                    endcase
                end
            end
            DCC_WR_RESP: begin
                if (s_ff.bvalid && s_axi_bready) begin
                    nxt_s.bvalid = 1'b0;
                    nxt_s.aw_got = 1'b0;
                    nxt_s.w_got = 1'b0;
                    nxt_s.awready = 1'b1;
                    nxt_s.wready = 1'b1;
                    nxt_s.wst = DCC_WR_COLLECT;
                end
            end
            default: begin
                nxt_s.wst = DCC_WR_COLLECT;
            end
        endcase
        // read channel
        case (s_ff.rst)
            DCC_RD_IDLE: begin
                nxt_s.arready = 1'b1;
                if (s_axi_arvalid && s_ff.arready) begin
                    nxt_s.arready = 1'b0;
                    nxt_s.rvalid = 1'b1;
                    nxt_s.rresp = `DCC_RESP_OKAY;
                    nxt_s.rst = DCC_RD_RESP;
                    case (s_axi_araddr)
                        `DCC_CTRL_OFS: nxt_s.rdata = ctrl_word;
                        `DCC_SWTRIG_OFS: nxt_s.rdata = 32'h0000_0000;
                        `DCC_HOLD_OFS: nxt_s.rdata = 32'(s_ff.hold);
                        `DCC_DOUT_OFS: nxt_s.rdata = 32'(s_ff.dout);
                        default: begin
                            nxt_s.rdata = 32'h0000_0000;
                            nxt_s.rresp = `DCC_RESP_SLVERR;
                        end
                    endcase
                end
            end
            DCC_RD_RESP: begin
                if (s_ff.rvalid && s_axi_rready) begin
                    nxt_s.rvalid = 1'b0;
                    nxt_s.arready = 1'b1;
                    nxt_s.rst = DCC_RD_IDLE;
                end
            end
            default: begin
                nxt_s.rst = DCC_RD_IDLE;
            end
        endcase
        // software trigger: a new request wins over consumption
        if (trig_evt && s_ff.tsel == DCC_TSEL_SW) begin
            nxt_s.sw_pend = 1'b0;
        end
        if (wr_do && s_ff.waddr == `DCC_SWTRIG_OFS &&
            wr_merged[`DCC_SW_BIT] && s_ff.trgen &&
            s_ff.tsel == DCC_TSEL_SW) begin
            nxt_s.sw_pend = 1'b1; // see [R8]
        end
        // load of the converter output register
        if (xfer) begin
            nxt_s.strobe = 1'b1; // see [R14]
            case (s_ff.wave)
                DCC_WAVE_NONE: begin
                    nxt_s.dout = s_ff.hold; // see [R9]
                end
                DCC_WAVE_NOISE: begin
                    nxt_s.lfsr = lfsr_nx;
                    nxt_s.dout = s_ff.hold + (lfsr_nx & mask); // see [R12]
                end
                DCC_WAVE_TRI, DCC_WAVE_TRI2: begin
                    nxt_s.tri_cnt = tri_nx;
                    nxt_s.tri_down = tri_dn_nx;
                    nxt_s.dout = s_ff.hold + tri_nx; // see [R10]
                end
                default: begin
                    nxt_s.dout = s_ff.hold;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_ff <= '0;
            s_ff.tsel <= DCC_TSEL_TIM6;
            s_ff.wave <= DCC_WAVE_NONE;
            s_ff.lfsr <= DAC_W'(`DCC_LFSR_RST);
            s_ff.wst <= DCC_WR_COLLECT;
            s_ff.rst <= DCC_RD_IDLE;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign s_axi_awready = s_ff.awready;
    assign s_axi_wready = s_ff.wready;
    assign s_axi_bvalid = s_ff.bvalid;
    assign s_axi_bresp = s_ff.bresp;
    assign s_axi_arready = s_ff.arready;
    assign s_axi_rvalid = s_ff.rvalid;
    assign s_axi_rdata = s_ff.rdata;
    assign s_axi_rresp = s_ff.rresp;
    assign ch2_enable = s_ff.en;
    assign ch2_output_buffer_off = s_ff.bufoff;
    assign ch2_data_out = s_ff.dout;
    assign ch2_conv_strobe = s_ff.strobe;

    default clocking dcc_cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_enable_by_write;
        $rose(ch2_enable) |-> $past(wr_do) &&
            $past(s_ff.waddr) == `DCC_CTRL_OFS;
    endproperty
    a_enable_by_write: assert property (p_enable_by_write) // see [R1]
        else $error("channel enable rose without a control write");

    property p_bufoff_by_write;
        $changed(ch2_output_buffer_off) |-> $past(wr_do) &&
            $past(s_ff.waddr) == `DCC_CTRL_OFS;
    endproperty
    a_bufoff_by_write: assert property (p_bufoff_by_write) // see [R2]
        else $error("buffer bypass changed without a control write");

    property p_trig_off_ignored;
        (s_ff.en && s_ff.trgen && !sel_evt) |=> !ch2_conv_strobe;
    endproperty
    a_trig_off_ignored: assert property (p_trig_off_ignored) // see [R3]
        else $error("load without a selected trigger event");

    property p_untrig_load;
        (s_ff.en && !s_ff.trgen) |=> ch2_conv_strobe;
    endproperty
    a_untrig_load: assert property (p_untrig_load) // see [R14]
        else $error("output not loaded in untriggered mode");

    property p_reserved_silent;
        (s_ff.trgen && s_ff.tsel == DCC_TSEL_RSVD) |=> !ch2_conv_strobe;
    endproperty
    a_reserved_silent: assert property (p_reserved_silent) // see [R6]
        else $error("reserved trigger code caused a load");

    property p_tim6_load;
        (s_ff.en && s_ff.trgen && s_ff.tsel == DCC_TSEL_TIM6 &&
         basic_timer_six_trig) |=> ch2_conv_strobe;
    endproperty
    a_tim6_load: assert property (p_tim6_load) // see [R5]
        else $error("timer six trigger did not load output");

    property p_tim7_load;
        (s_ff.en && s_ff.trgen && s_ff.tsel == DCC_TSEL_TIM7 &&
         basic_timer_seven_trig) |=> ch2_conv_strobe;
    endproperty
    a_tim7_load: assert property (p_tim7_load) // see [R13]
        else $error("timer seven trigger did not load output");

    property p_eint_load;
        (s_ff.en && s_ff.trgen && s_ff.tsel == DCC_TSEL_EINT9 &&
         eint_line9_trig) |=> ch2_conv_strobe;
    endproperty
    a_eint_load: assert property (p_eint_load) // see [R7]
        else $error("interrupt line trigger did not load output");

    property p_sw_load;
        (s_ff.en && s_ff.trgen && s_ff.tsel == DCC_TSEL_SW &&
         s_ff.sw_pend) |=> ch2_conv_strobe;
    endproperty
    a_sw_load: assert property (p_sw_load) // see [R8]
        else $error("software trigger did not load output");

    property p_no_wave;
        (xfer && s_ff.wave == DCC_WAVE_NONE) |=>
            ch2_data_out == $past(s_ff.hold);
    endproperty
    a_no_wave: assert property (p_no_wave) // see [R9]
        else $error("plain mode output differs from held data");

    property p_tri_step;
        (xfer && s_ff.wave[1] && !s_ff.tri_down && s_ff.tri_cnt < mask)
            |=> s_ff.tri_cnt == $past(s_ff.tri_cnt) + DAC_W'(1);
    endproperty
    a_tri_step: assert property (p_tri_step) // see [R10]
        else $error("triangle did not step up");

    property p_tri_peak;
        s_ff.wave[1] && $past(xfer) && $past(s_ff.wave[1]) &&
            $past(s_ff.tri_cnt) <= $past(mask) |-> s_ff.tri_cnt <= mask;
    endproperty
    a_tri_peak: assert property (p_tri_peak) // see [R11]
        else $error("triangle exceeded selected amplitude");

    property p_noise_step;
        (xfer && s_ff.wave == DCC_WAVE_NOISE) |=>
            s_ff.lfsr != $past(s_ff.lfsr) &&
            ((ch2_data_out - s_ff.hold) & ~mask) == '0;
    endproperty
    a_noise_step: assert property (p_noise_step) // see [R12]
        else $error("noise register did not advance within mask");

    c_noise: cover property (xfer && s_ff.wave == DCC_WAVE_NOISE);
    c_tri_peak: cover property (xfer && s_ff.wave[1] &&
                                s_ff.tri_cnt == mask);
    c_sw_trig: cover property (trig_evt && s_ff.tsel == DCC_TSEL_SW);
    c_wr_resp: cover property (s_axi_bvalid && s_axi_bready);

endmodule

// ===== dcc_trig_src.sv
`timescale 1ns/100ps

// trigger pulses from the timers and the interrupt line, each a copy of its fire bit delayed by one cycle
module dcc_trig_src (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [5:0] fire,
    output logic basic_timer_six_trig,
    output logic basic_timer_seven_trig,
    output logic general_timer_three_trig,
    output logic general_timer_fifteen_trig,
    output logic general_timer_two_trig,
    output logic eint_line9_trig
);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {eint_line9_trig, general_timer_two_trig,
             general_timer_fifteen_trig, general_timer_three_trig,
             basic_timer_seven_trig, basic_timer_six_trig} <= 6'h00;
        end else begin
            {eint_line9_trig, general_timer_two_trig,
             general_timer_fifteen_trig, general_timer_three_trig,
             basic_timer_seven_trig, basic_timer_six_trig} <= fire;
        end
    end
endmodule

// ===== dcc_ch2_ctrl_test.sv
`timescale 1ns/100ps
`include "dcc_map.svh"

module dcc_ch2_ctrl_test;
    import dcc_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [5:0] fire = 6'h00;
    logic [31:0] rdata;
    logic awready, wready, bvalid, arready, rvalid, strobe;
    logic ch2_enable, buf_off;
    logic [1:0] bresp, rresp, rs;
    logic [11:0] dout, h, lf;
    logic [5:0] trg;
    logic [31:0] rd;
    logic [11:0] exp_q[$];
    int err_total = 0;
    int tests_run = 0;
    int cyc = 0;
    bit chk_on = 1'b1;

    always #2 aclk = ~aclk;

    dcc_trig_src src (.aclk(aclk), .aresetn(aresetn), .fire(fire),
        .basic_timer_six_trig(trg[0]), .basic_timer_seven_trig(trg[1]),
        .general_timer_three_trig(trg[2]),
        .general_timer_fifteen_trig(trg[3]),
        .general_timer_two_trig(trg[4]), .eint_line9_trig(trg[5]));

    dcc_ch2_ctrl #(.DAC_W(12)) dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .basic_timer_six_trig(trg[0]),
        .basic_timer_seven_trig(trg[1]), .general_timer_three_trig(trg[2]),
        .general_timer_fifteen_trig(trg[3]),
        .general_timer_two_trig(trg[4]), .eint_line9_trig(trg[5]),
        .ch2_enable(ch2_enable), .ch2_output_buffer_off(buf_off),
        .ch2_data_out(dout), .ch2_conv_strobe(strobe));

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic end_of_test;
        if (err_total == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        bit aw;
        bit w;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw = 1'b1;
        w = 1'b1;
        forever begin
            @(posedge aclk);
            if (aw && awready) begin
                awvalid <= 1'b0;
                aw = 1'b0;
            end
            if (w && wready) begin
                wvalid <= 1'b0;
                w = 1'b0;
            end
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rdr(input logic [7:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        bit ar;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        ar = 1'b1;
        forever begin
            @(posedge aclk);
            if (ar && arready) begin
                arvalid <= 1'b0;
                ar = 1'b0;
            end
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask

    function automatic logic [31:0] ctl(logic en, logic bo, logic tg,
        logic [2:0] ts, logic [1:0] wv, logic [3:0] ma);
        return (32'(en) << `DCC_EN_BIT) | (32'(bo) << `DCC_BUFOFF_BIT)
            | (32'(tg) << `DCC_TRGEN_BIT) | (32'(ts) << `DCC_TSEL_LSB)
            | (32'(wv) << `DCC_WAVE_LSB) | (32'(ma) << `DCC_MAMP_LSB);
    endfunction

    // write control, then read it back
    task automatic setc(input logic [31:0] v);
        wr(`DCC_CTRL_OFS, v, rs);
        chk("ctrl bresp", 32'(`DCC_RESP_OKAY), 32'(rs));
        rdr(`DCC_CTRL_OFS, rd, rs);
        chk("ctrl readback", v, rd);
    endtask

    // source bit for each select code; none for reserved and software
    function automatic logic [5:0] sel(logic [2:0] c);
        case (c)
            3'h0: return 6'h01;
            3'h1: return 6'h04;
            3'h2: return 6'h02;
            3'h3: return 6'h08;
            3'h4: return 6'h10;
            3'h6: return 6'h20;
            default: return 6'h00;
        endcase
    endfunction

    task automatic pulse(input logic [5:0] f);
        @(posedge aclk);
        fire <= f;
        @(posedge aclk);
        fire <= 6'h00;
        repeat (4) @(posedge aclk);
        chk("loads left", 32'h0, 32'(exp_q.size()));
    endtask

    task automatic fire_src(input logic [2:0] c);
        if (c == 3'h7) begin
            wr(`DCC_SWTRIG_OFS, 32'h2, rs);
            pulse(6'h00);
        end else begin
            pulse(sel(c));
        end
    endtask

    always @(posedge aclk) begin
        if (aresetn && chk_on && strobe) begin
            if (exp_q.size() == 0) begin
                chk("stray strobe", 32'h0, 32'h1);
            end else begin
                chk("data out", 32'(exp_q.pop_front()),
                    32'(dout));
            end
        end
    end

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            err_total++;
            end_of_test();
        end
    end

    initial begin
        void'($urandom(90404));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rdr(`DCC_CTRL_OFS, rd, rs);
        chk("ctrl reset", `DCC_CTRL_RST, rd);
        chk("enable reset", 32'h0, 32'(ch2_enable));
        wr(8'h10, 32'hffff_ffff, rs);
        chk("unmapped bresp", 32'(`DCC_RESP_SLVERR), 32'(rs));
        rdr(8'h10, rd, rs);
        chk("unmapped rresp", 32'(`DCC_RESP_SLVERR), 32'(rs));
        chk("unmapped rdata", 32'h0, rd);
        // disabled channel ignores every hardware trigger
        setc(ctl(1'b0, 1'b0, 1'b1, 3'h0, 2'h0, 4'h0));
        wr(`DCC_HOLD_OFS, 32'($urandom) & 32'hfff, rs);
        pulse(6'h3f);
        for (int c = 0; c < 8; c++) begin
            h = 12'($urandom);
            setc(ctl(1'b1, c[0], 1'b1, c[2:0], 2'h0, 4'h0));
            chk("enable", 32'h1, 32'(ch2_enable));
            chk("buffer off", 32'(c[0]), 32'(buf_off));
            wr(`DCC_HOLD_OFS, 32'(h), rs);
            pulse(~sel(c[2:0]));
            if (c != 5) begin
                exp_q.push_back(h);
                fire_src(c[2:0]);
                rdr(`DCC_DOUT_OFS, rd, rs);
                chk("dout reg", 32'(h), rd);
            end
        end
        // triangle, peak 3, counts up then down; lower wave bit ignored
        setc(ctl(1'b1, 1'b0, 1'b1, 3'h7, 2'h2, 4'h1));
        h = 12'($urandom);
        wr(`DCC_HOLD_OFS, 32'(h), rs);
        for (int i = 0; i < 6; i++) begin
            if (i == 3) begin
                setc(ctl(1'b1, 1'b0, 1'b1, 3'h7, 2'h3, 4'h1));
            end
            exp_q.push_back(h + 12'((i < 3) ? i + 1 : 5 - i));
            fire_src(3'h7);
        end
        // noise with the low four bits unmasked
        setc(ctl(1'b1, 1'b0, 1'b1, 3'h7, 2'h1, 4'h3));
        lf = `DCC_LFSR_RST;
        for (int i = 0; i < 4; i++) begin
            lf = {lf[10:0], lf[11] ^ lf[5] ^ lf[3] ^ lf[0]};
            exp_q.push_back(h + (lf & 12'h00f));
            fire_src(3'h7);
        end
        // untriggered: output follows the pending data every clock
        chk_on = 1'b0;
        setc(ctl(1'b1, 1'b0, 1'b0, 3'h0, 2'h0, 4'h0));
        h = 12'($urandom);
        wr(`DCC_HOLD_OFS, 32'(h), rs);
        repeat (3) @(posedge aclk);
        chk("free run data", 32'(h), 32'(dout));
        end_of_test();
    end
endmodule
